// file: design/svm_supply_monitor.sv
/*
 svm_supply_monitor: register file and control for two supply voltage detectors,
 AXI4-Lite slave. Assumes comparator outputs and the slow oscillator are asynchronous
 pins; i_sys_rst is power-on/hardware reset, i_warm_rst the other chip resets.
*/
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module svm_supply_monitor
    import svm_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_warm_rst,
    input  wire logic        i_cmp_det1,
    input  wire logic        i_cmp_det2,
    input  wire logic        i_slow_osc,
    input  wire logic        i_wdt_detect,
    input  wire logic        i_wp_unlock,
    input  wire logic [11:0] i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [11:0] i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    output logic             o_irq_req,
    output logic             o_chip_reset_req,
    output logic [1:0]       o_det_enable,
    output logic             o_low_power
);
    typedef struct packed {
        logic       awrdy;
        logic       aw_ok;
        logic [9:0] awa;
        logic       wrdy;
        logic       w_ok;
        logic [7:0] wd;
        logic       wst;
        logic       bvalid;
        logic [1:0] bresp;
        logic       arrdy;
        logic       rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] lvl_rsv;
        logic [7:0] ena;
        logic [7:0] m1;
        logic [7:0] m2;
        logic [1:0] xflag;
        logic       wflag;
        logic [2:0] osc;
        logic       irq;
        logic       chip_rst;
    } svm_top_t;

    svm_top_t   st_r;
    svm_top_t   st_nxt;
    svm_cfg_t   cfg_w [2];
    logic [1:0] cmp_w;
    logic [1:0] lvl_w;
    logic [1:0] evt_w;
    logic [1:0] rst_w;
    logic [1:0] xclr;
    logic       wclr;
    logic       hit;
    logic       tick;
    logic [7:0] rd;

    assign cmp_w = {i_cmp_det2, i_cmp_det1};
    assign tick  = st_r.osc[1] & ~st_r.osc[2];

    // generation gated by circuit enable inside unit
    assign cfg_w[0] = '{en: st_r.ena[B_DET1_EN], gen_en: st_r.m1[B_GEN_EN],
                        filt_dis: st_r.m1[B_FILT_DIS], div: st_r.m1[B_DIV_LO +: 2],
                        mode: st_r.m1[B_MODE], cond: st_r.m1[B_COND]};
    assign cfg_w[1] = '{en: st_r.ena[B_DET1_EN + 1], gen_en: st_r.m2[B_GEN_EN],
                        filt_dis: st_r.m2[B_FILT_DIS], div: st_r.m2[B_DIV_LO +: 2],
                        mode: st_r.m2[B_MODE], cond: st_r.m2[B_COND]};

    svm_mon_if mon_if [2] ();

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_mon
            assign mon_if[g].cfg  = cfg_w[g];
            assign mon_if[g].tick = tick;
            assign lvl_w[g] = mon_if[g].level;
            assign evt_w[g] = mon_if[g].evt;
            assign rst_w[g] = mon_if[g].rst_act;
            svm_mon_unit u_unit (
                .i_clk     (i_clk),
                .i_sys_rst (i_sys_rst),
                .i_cmp     (cmp_w[g]),
                .mon       (mon_if[g])
            );
        end
    endgenerate

    always_comb
    begin
        st_nxt = st_r;
        xclr = 2'h0;
        wclr = 1'b0;
        hit = 1'b0;
        rd = 8'h00;
        // slow oscillator sync plus edge history
        st_nxt.osc = {st_r.osc[1:0], i_slow_osc};

        if (i_awvalid && st_r.awrdy)
        begin
            st_nxt.aw_ok = 1'b1;
            st_nxt.awa = i_awaddr[11:2];
        end
        if (i_wvalid && st_r.wrdy)
        begin
            st_nxt.w_ok = 1'b1;
            st_nxt.wd = i_wdata[7:0];
            st_nxt.wst = i_wstrb[0];
        end
        if (st_r.bvalid && i_bready)
            st_nxt.bvalid = 1'b0;

        // no register write lands while a warm reset is held
        if (st_r.aw_ok && st_r.w_ok && !st_r.bvalid && !i_warm_rst)
        begin
            st_nxt.aw_ok = 1'b0;
            st_nxt.w_ok = 1'b0;
            st_nxt.bvalid = 1'b1;
            hit = 1'b1;
            if (st_r.awa == {2'h0, IDX_LEVEL})
            begin
                if (st_r.wst)
                    st_nxt.lvl_rsv = st_r.wd & MASK_LEVEL_RW;
            end
            else if (st_r.awa == {2'h0, IDX_ENABLE})
            begin
                if (st_r.wst && i_wp_unlock)
                    st_nxt.ena = st_r.wd;
            end
            else if (st_r.awa == {2'h0, IDX_MON1})
            begin
                if (st_r.wst)
                begin
                    st_nxt.m1 = st_r.wd & MASK_MON_CTL;
                    xclr[0] = ~st_r.wd[B_XFLAG];
                end
            end
            else if (st_r.awa == {2'h0, IDX_MON2})
            begin
                if (st_r.wst)
                begin
                    st_nxt.m2 = st_r.wd & MASK_MON_CTL;
                    xclr[1] = ~st_r.wd[B_XFLAG];
                    wclr = ~st_r.wd[B_WFLAG];
                end
            end
            else
                hit = 1'b0;
            st_nxt.bresp = hit ? RESP_OKAY : RESP_SLVERR;
        end

        // write 0 clears, 1 keeps; hardware set wins
        st_nxt.xflag = (st_r.xflag & ~xclr) | evt_w;
        st_nxt.wflag = (st_r.wflag & ~wclr) | i_wdt_detect;

        if (st_r.rvalid && i_rready)
            st_nxt.rvalid = 1'b0;
        if (i_arvalid && st_r.arrdy)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = RESP_OKAY;
            unique case (i_araddr[11:2])
                {2'h0, IDX_LEVEL}:
                    rd = st_r.lvl_rsv | (8'(lvl_w[1]) << B_DET2_LVL);
                {2'h0, IDX_ENABLE}:
                    rd = st_r.ena;
                {2'h0, IDX_MON1}:
                    rd = st_r.m1 | (8'(lvl_w[0]) << B_WFLAG) | (8'(st_r.xflag[0]) << B_XFLAG);
                {2'h0, IDX_MON2}:
                    rd = st_r.m2 | (8'(st_r.wflag) << B_WFLAG) | (8'(st_r.xflag[1]) << B_XFLAG);
                default:
                    st_nxt.rresp = RESP_SLVERR;
            endcase
            st_nxt.rdata = rd;
        end

        st_nxt.awrdy = !st_nxt.aw_ok && !st_nxt.bvalid;
        st_nxt.wrdy = !st_nxt.w_ok && !st_nxt.bvalid;
        st_nxt.arrdy = !st_nxt.rvalid;

        // interrupt request only in interrupt mode
        st_nxt.irq = |(evt_w & {cfg_w[1].gen_en & ~cfg_w[1].mode, cfg_w[0].gen_en & ~cfg_w[0].mode});
        // chip reset sends the CPU back to its reset vector
        st_nxt.chip_rst = |rst_w;

        if (i_warm_rst)
        begin
            st_nxt.m1 = RST_MON;
            st_nxt.m2 = RST_MON;
            st_nxt.lvl_rsv = RST_LEVEL & MASK_LEVEL_RW;
            st_nxt.aw_ok = 1'b0;
            st_nxt.w_ok = 1'b0;
            st_nxt.bvalid = 1'b0;
            st_nxt.rvalid = 1'b0;
            st_nxt.awrdy = 1'b0;
            st_nxt.wrdy = 1'b0;
            st_nxt.arrdy = 1'b0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            st_r <= '{ena: RST_ENABLE, m1: RST_MON, m2: RST_MON,
                      lvl_rsv: RST_LEVEL & MASK_LEVEL_RW, default: '0};
        else
            st_r <= st_nxt;
    end

    assign o_awready        = st_r.awrdy;
    assign o_wready         = st_r.wrdy;
    assign o_bvalid         = st_r.bvalid;
    assign o_bresp          = st_r.bresp;
    assign o_arready        = st_r.arrdy;
    assign o_rvalid         = st_r.rvalid;
    assign o_rresp          = st_r.rresp;
    assign o_rdata          = {24'h000000, st_r.rdata};
    assign o_irq_req        = st_r.irq;
    assign o_chip_reset_req = st_r.chip_rst;
    assign o_det_enable     = st_r.ena[B_DET1_EN +: 2];
    assign o_low_power      = st_r.ena[B_LOW_PWR];

    a_flag_set_wins: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        evt_w[1] |=> st_r.xflag[1]) else $error("crossing flag lost on clear");
    a_flag_warm_keep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_warm_rst && !i_wdt_detect && evt_w == 2'h0) |=> $stable(st_r.xflag) && $stable(st_r.wflag))
        else $error("flags changed by warm reset");
    a_enable_warm_keep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_warm_rst |=> $stable(st_r.ena)) else $error("enable register changed by warm reset");
    a_irq_mode_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (evt_w != 2'h0 && (evt_w & ~{cfg_w[1].mode, cfg_w[0].mode}) == 2'h0) |=> !o_irq_req)
        else $error("interrupt in reset mode");
    a_reset_follows: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (|rst_w) |=> o_chip_reset_req) else $error("chip reset not requested");
    a_write_response: assert property (@(posedge i_clk) disable iff (i_sys_rst || i_warm_rst)
        (i_awvalid && o_awready && i_wvalid && o_wready) |-> ##2 o_bvalid) else $error("write answer late");
endmodule

// file: design/svm_pkg.sv
/*
 svm_pkg: constants and types for the supply voltage monitor logic.
 Assumes a 40 MHz system clock; register indices are word indices on AXI4-Lite.
*/
package svm_pkg;
    localparam int CLK_PERIOD_NS = 25;
    // release delay after the supply recovers in reset mode
    localparam int RST_HOLD_NS   = 2000;
    localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W        = $clog2(RST_HOLD_CYC + 1);
    localparam int FILT_SAMPLES  = 4;

    localparam logic [7:0] IDX_LEVEL  = 8'h31;
    localparam logic [7:0] IDX_ENABLE = 8'h32;
    localparam logic [7:0] IDX_MON1   = 8'h36;
    localparam logic [7:0] IDX_MON2   = 8'h37;

    localparam logic [7:0] RST_LEVEL  = 8'h08;
    localparam logic [7:0] RST_ENABLE = 8'h20;
    localparam logic [7:0] RST_MON    = 8'h00;

    localparam int B_DET2_LVL = 3;
    localparam int B_LOW_PWR  = 0;
    localparam int B_DET1_EN  = 6;
    localparam int B_GEN_EN   = 0;
    localparam int B_FILT_DIS = 1;
    localparam int B_XFLAG    = 2;
    localparam int B_WFLAG    = 3;
    localparam int B_DIV_LO   = 4;
    localparam int B_MODE     = 6;
    localparam int B_COND     = 7;

    localparam logic [7:0] MASK_LEVEL_RW = 8'hF7;
    localparam logic [7:0] MASK_MON_CTL  = 8'hF3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       en;
        logic       gen_en;
        logic       filt_dis;
        logic [1:0] div;
        logic       mode;
        logic       cond;
    } svm_cfg_t;
endpackage

// file: design/svm_mon_if.sv
/*
 svm_mon_if: configuration and status between the register file and one monitor unit.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface svm_mon_if;
    import svm_pkg::*;
    svm_cfg_t cfg;
    logic     tick;
    logic     level;
    logic     evt;
    logic     rst_act;
    modport ctrl (output cfg, output tick, input level, input evt, input rst_act);
    modport unit (input cfg, input tick, output level, output evt, output rst_act);
endinterface

// file: design/svm_mon_unit.sv
/*
 svm_mon_unit: one detector's synchroniser, sample divider, digital filter,
 crossing detector and reset-hold timer. Assumes tick is a one-cycle pulse per
 slow oscillator period, already synchronised.
*/
`timescale 1ns/1ps
module svm_mon_unit
    import svm_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_cmp,
    svm_mon_if.unit   mon
);
    typedef struct packed {
        logic              s1;
        logic              s2;
        logic [2:0]        dcnt;
        logic [1:0]        fcnt;
        logic              flt;
        logic              lvl;
        logic              evt;
        logic              rst;
        logic [HOLD_W-1:0] hold;
    } svm_unit_t;

    svm_unit_t  st_r;
    svm_unit_t  st_nxt;
    logic       sample;
    logic       lvl;
    logic [2:0] div_max;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.evt = 1'b0;
        st_nxt.s1 = i_cmp;
        st_nxt.s2 = st_r.s1;
        sample = 1'b0;
        div_max = (3'h1 << mon.cfg.div) - 3'h1;
        if (mon.tick)
        begin
            if (st_r.dcnt >= div_max)
            begin
                st_nxt.dcnt = 3'h0;
                sample = 1'b1;
            end
            else
                st_nxt.dcnt = st_r.dcnt + 3'h1;
        end
        // new level needs four agreeing samples
        if (sample)
        begin
            if (st_r.s2 == st_r.flt)
                st_nxt.fcnt = 2'h0;
            else if (st_r.fcnt == 2'(FILT_SAMPLES - 1))
            begin
                st_nxt.flt = st_r.s2;
                st_nxt.fcnt = 2'h0;
            end
            else
                st_nxt.fcnt = st_r.fcnt + 2'h1;
        end
        lvl = mon.cfg.filt_dis ? st_r.s2 : st_r.flt;
        st_nxt.lvl = mon.cfg.en ? lvl : 1'b1;
        if (mon.cfg.en)
        begin
            // filtered: both ways; condition only when bypassed
            if (!mon.cfg.filt_dis)
                st_nxt.evt = st_nxt.lvl ^ st_r.lvl;
            // rising when 0, falling when 1
            else if (mon.cfg.cond)
                st_nxt.evt = st_r.lvl & ~st_nxt.lvl;
            else
                st_nxt.evt = ~st_r.lvl & st_nxt.lvl;
        end
        else
        begin
            st_nxt.flt = 1'b1;
            st_nxt.fcnt = 2'h0;
            st_nxt.dcnt = 3'h0;
        end
        // hold while low, release after delay
        // warm reset clears the mode bits: a running hold must still last while low
        if (mon.cfg.en && !st_nxt.lvl && (st_r.rst || (mon.cfg.gen_en && mon.cfg.mode)))
        begin
            st_nxt.rst = 1'b1;
            st_nxt.hold = HOLD_W'(RST_HOLD_CYC);
        end
        else if (st_r.rst)
        begin
            if (st_r.hold <= HOLD_W'(1))
                st_nxt.rst = 1'b0;
            st_nxt.hold = st_r.hold - HOLD_W'(1);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            st_r <= '{s1: 1'b1, s2: 1'b1, flt: 1'b1, lvl: 1'b1, default: '0};
        else
            st_r <= st_nxt;
    end

    assign mon.level   = st_r.lvl;
    assign mon.evt     = st_r.evt;
    assign mon.rst_act = st_r.rst;

    a_disabled_level: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !mon.cfg.en |=> mon.level) else $error("disabled detector level not 1");
    a_reset_release: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        $fell(mon.rst_act) |-> $past(mon.level, 1) && $past(mon.level, 2)) else $error("reset released while low");
    a_filter_edges: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (mon.cfg.en && !mon.cfg.filt_dis && $changed(mon.level) && $stable(mon.cfg)) |-> mon.evt)
        else $error("filtered crossing missed");
endmodule

// file: verif/svm_supply_model.sv
/*
 svm_supply_model: far side of the monitor, two supply comparators, a free-running
 slow oscillator and the system reset logic. Assumes the bench commands supply levels.
*/
`timescale 1ns/1ps
module svm_supply_model
#(
    parameter int OSC_HALF_NS = 100
)
(
    input  wire logic       i_clk,
    input  wire logic [1:0] i_lvl,
    input  wire logic [1:0] i_det_enable,
    input  wire logic       i_chip_reset_req,
    output logic            o_cmp_det1,
    output logic            o_cmp_det2,
    output logic            o_slow_osc = 1'b0,
    output logic            o_warm_rst = 1'b0
);
    logic tog = 1'b0;

    // odd start offset keeps the oscillator off the system clock grid
    initial
    begin
        #7;
        forever #(OSC_HALF_NS) o_slow_osc = ~o_slow_osc;
    end

    always @(posedge i_clk)
        tog <= ~tog;

    // a powered-down comparator gives no usable level
    assign #3 o_cmp_det1 = i_det_enable[0] ? i_lvl[0] : tog;
    assign #3 o_cmp_det2 = i_det_enable[1] ? i_lvl[1] : tog;

    always @(posedge i_clk)
        o_warm_rst <= i_chip_reset_req;
endmodule

// file: verif/test_supply_voltage_monitor_logic.sv
/*
 test_supply_voltage_monitor_logic: self-checking bench for svm_supply_monitor.
 Assumes svm_pkg and the supply model; registers reached over AXI4-Lite.
*/
`timescale 1ns/1ps
module test_supply_voltage_monitor_logic;
    import svm_pkg::*;
    localparam int OSC_CYC = 8;
    localparam int TMO     = 20000;
    logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_wdt_detect = 1'b0, i_wp_unlock = 1'b0;
    logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic [11:0] i_awaddr = 12'h000, i_araddr = 12'h000;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0]  i_wstrb = 4'hF;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq_req, o_chip_reset_req, o_low_power;
    logic [1:0]  o_bresp, o_rresp, o_det_enable;
    logic [31:0] o_rdata;
    logic        i_cmp_det1, i_cmp_det2, i_slow_osc, i_warm_rst;
    logic [1:0]  lvl = 2'b11;
    logic [11:0] a;
    logic [7:0]  r8;
    logic [1:0]  dv;
    int          errors = 0, checks = 0, irq_cnt = 0, cyc = 0, ib, g;

    svm_supply_monitor i_svm_supply_monitor (.i_clk, .i_sys_rst, .i_warm_rst, .i_cmp_det1, .i_cmp_det2,
        .i_slow_osc, .i_wdt_detect, .i_wp_unlock, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
        .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
        .o_rresp, .o_rvalid, .i_rready, .o_irq_req, .o_chip_reset_req, .o_det_enable, .o_low_power);

    svm_supply_model #(.OSC_HALF_NS(OSC_CYC * 25 / 2)) i_svm_supply_model (.i_clk, .i_lvl(lvl),
        .i_det_enable(o_det_enable), .i_chip_reset_req(o_chip_reset_req), .o_cmp_det1(i_cmp_det1),
        .o_cmp_det2(i_cmp_det2), .o_slow_osc(i_slow_osc), .o_warm_rst(i_warm_rst));

    always #12.5 i_clk = ~i_clk;

    task automatic summarize();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (o_irq_req === 1'b1)
            irq_cnt <= irq_cnt + 1;
        if (cyc == TMO)
        begin
            errors++;
            summarize();
        end
    end

    // cycles to settle a filtered change: six sample periods plus 16 cycles of sync margin
    function automatic int filt_wait(input logic [1:0] d);
        return 6 * (1 << d) * OSC_CYC + 16;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] ad, input logic [7:0] d, input logic [1:0] er);
        @(posedge i_clk);
        i_awaddr  <= ad;
        i_wdata   <= ($urandom() << 8) | d;
        i_awvalid <= 1'b1;
        i_wvalid  <= 1'b1;
        i_bready  <= 1'b1;
        do
        begin
            @(posedge i_clk);
            if (i_awvalid && o_awready)
                i_awvalid <= 1'b0;
            if (i_wvalid && o_wready)
                i_wvalid <= 1'b0;
        end
        while (!(o_bvalid === 1'b1));
        i_bready <= 1'b0;
        chk({30'h0, o_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [11:0] ad, input logic [31:0] exp, input logic [31:0] m, input logic [1:0] er);
        logic [31:0] v;
        logic [1:0]  r;
        @(posedge i_clk);
        i_araddr  <= ad;
        i_arvalid <= 1'b1;
        i_rready  <= 1'b1;
        do
        begin
            @(posedge i_clk);
            if (i_arvalid && o_arready)
                i_arvalid <= 1'b0;
            v = o_rdata;
            r = o_rresp;
        end
        while (!(o_rvalid === 1'b1));
        i_rready <= 1'b0;
        chk(v & m, exp);
        chk({30'h0, r}, {30'h0, er});
    endtask

    task automatic cfg(input logic [11:0] ad, input logic [7:0] v);
        wr(ad, v & 8'hFE, RESP_OKAY);
        if (!v[B_FILT_DIS])
            repeat (filt_wait(v[5:4])) @(posedge i_clk);
        wr(ad, v, RESP_OKAY);
    endtask

    task automatic sup(input int m, input logic v, input int n);
        @(posedge i_clk);
        lvl[m] <= v;
        repeat (n) @(posedge i_clk);
    endtask

    initial
    begin
        void'($urandom(32'hE2D5));
        repeat (20) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (3) @(posedge i_clk);
        rd(12'h0C4, 8'h08, 8'hFF, RESP_OKAY);
        rd(12'h0C8, 8'h20, 8'hFF, RESP_OKAY);
        rd(12'h0D8, 8'h08, 8'hFF, RESP_OKAY);
        rd(12'h0DC, 8'h00, 8'hFF, RESP_OKAY);
        rd(12'h100, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
        wr(12'h104, 8'h5A, RESP_SLVERR);
        r8 = 8'($urandom());
        wr(12'h0C4, r8, RESP_OKAY);
        rd(12'h0C4, (r8 & 8'hF7) | 8'h08, 8'hFF, RESP_OKAY);
        // locked enable register ignores writes
        wr(12'h0C8, 8'hC1, RESP_OKAY);
        rd(12'h0C8, 8'h20, 8'hFF, RESP_OKAY);
        i_wp_unlock <= 1'b1;
        wr(12'h0C8, 8'hC1, RESP_OKAY);
        rd(12'h0C8, 8'hC1, 8'hFF, RESP_OKAY);
        chk({30'h0, o_det_enable}, 32'h3);
        chk({31'h0, o_low_power}, 32'h1);
        repeat (20) @(posedge i_clk);
        // filter is on after reset, so the level flag lags by four samples
        sup(1, 1'b0, filt_wait(2'h0));
        rd(12'h0C4, 8'h00, 8'h08, RESP_OKAY);
        rd(12'h0D8, 8'h08, 8'h08, RESP_OKAY);
        sup(1, 1'b1, filt_wait(2'h0));
        rd(12'h0C4, 8'h08, 8'h08, RESP_OKAY);
        for (int m = 0; m < 2; m++)
        begin
            a = (m == 1) ? 12'h0DC : 12'h0D8;
            cfg(a, 8'h03);
            ib = irq_cnt;
            sup(m, 1'b0, 10);
            chk(irq_cnt - ib, 0);
            rd(a, 8'h03, 8'hF7, RESP_OKAY);
            sup(m, 1'b1, 10);
            chk(irq_cnt - ib, 1);
            rd(a, 8'h07, 8'hF7, RESP_OKAY);
            wr(a, 8'h83, RESP_OKAY);
            rd(a, 8'h83, 8'hF7, RESP_OKAY);
            wr(a, 8'h87, RESP_OKAY);
            rd(a, 8'h83, 8'hF7, RESP_OKAY);
            sup(m, 1'b0, 10);
            chk(irq_cnt - ib, 2);
            rd(a, 8'h87, 8'hF7, RESP_OKAY);
            sup(m, 1'b1, 10);
            chk(irq_cnt - ib, 2);
            wr(a, 8'h82, RESP_OKAY);
            sup(m, 1'b0, 10);
            sup(m, 1'b1, 10);
            chk(irq_cnt - ib, 2);
            wr(a, 8'h00, RESP_OKAY);
        end
        cfg(12'h0DC, 8'h03);
        wr(12'h0C8, 8'h40, RESP_OKAY);
        ib = irq_cnt;
        sup(1, 1'b0, 10);
        rd(12'h0C4, 8'h08, 8'h08, RESP_OKAY);
        sup(1, 1'b1, 10);
        chk(irq_cnt - ib, 0);
        // clear generation first: re-enable may glitch the synced level
        wr(12'h0DC, 8'h00, RESP_OKAY);
        wr(12'h0C8, 8'hC0, RESP_OKAY);
        repeat (20) @(posedge i_clk);
        for (int d = 0; d < 4; d++)
        begin
            dv = 2'(d);
            cfg(12'h0DC, {dv[0], 1'b0, dv, 4'b0001});
            ib = irq_cnt;
            g = OSC_CYC * (1 << d) * (1 + int'($urandom() % 2));
            sup(1, 1'b0, g);
            sup(1, 1'b1, filt_wait(dv));
            chk(irq_cnt - ib, 0);
            sup(1, 1'b0, filt_wait(dv));
            chk(irq_cnt - ib, 1);
            sup(1, 1'b1, filt_wait(dv));
            chk(irq_cnt - ib, 2);
        end
        wr(12'h0DC, 8'h00, RESP_OKAY);
        @(posedge i_clk);
        i_wdt_detect <= 1'b1;
        @(posedge i_clk);
        i_wdt_detect <= 1'b0;
        // reset mode uses condition 1; bit3 kept at 1 so the watchdog flag survives
        // filter bypassed, as needed for a wake from stop
        cfg(12'h0DC, 8'hCB);
        ib = irq_cnt;
        sup(1, 1'b0, 10);
        chk({31'h0, o_chip_reset_req}, 32'h1);
        chk(irq_cnt - ib, 0);
        sup(1, 1'b1, 60);
        chk({31'h0, o_chip_reset_req}, 32'h1);
        repeat (40) @(posedge i_clk);
        chk({31'h0, o_chip_reset_req}, 32'h0);
        repeat (5) @(posedge i_clk);
        rd(12'h0DC, 8'h0C, 8'hFF, RESP_OKAY);
        rd(12'h0C8, 8'hC0, 8'hFF, RESP_OKAY);
        wr(12'h0DC, 8'h00, RESP_OKAY);
        rd(12'h0DC, 8'h00, 8'hFF, RESP_OKAY);
        summarize();
    end
endmodule
